// ==== logic/rcmi_pkg.sv ====
/*
 * constants, sequencer states and the packed state record of the
 * reset, clock and mode initialisation block.
 * assumes: shared by the block's top module, the board model and the testbench.
 */
package rcmi_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int AD_W   = 32;  // shared address/data bus
  localparam int CMD_W  = 9;   // command bus
  localparam int REG_AW = 8;   // register port address
  localparam int REG_DW = 32;  // register port data
  localparam int CNT_W  = 3;   // bus clock phase counter

  // ****************************************
  // fixed bus values and boot address
  // ****************************************
  localparam logic [CMD_W-1:0] CMD_COLD     = 9'h1D0;
  localparam logic [AD_W-1:0]  AD_COLD      = 32'h0000_0000;
  localparam logic [AD_W-1:0]  RESET_VECTOR = 32'hBFC0_0000;
  localparam logic [2:0]       UNCACHED_SEG = 3'h5;  // top address bits
  localparam int               SEG_HI       = 31;
  localparam int               SEG_LO       = 29;

  // ****************************************
  // register offsets and field positions
  // ****************************************
  localparam logic [REG_AW-1:0] OFS_CONFIG = 8'h00;  // read only
  localparam logic [REG_AW-1:0] OFS_STATUS = 8'h04;  // read/write
  localparam logic [REG_AW-1:0] OFS_SEQ    = 8'h08;  // read only
  localparam int CFG_BIG      = 0;
  localparam int CFG_PROTO    = 1;
  localparam int CFG_RATIO_LO = 2;
  localparam int CFG_TIMER    = 4;
  localparam int STS_REV      = 0;
  localparam int SEQ_STATE_LO = 0;
  localparam int SEQ_RUN      = 3;
  localparam int SEQ_MASTER   = 4;

  // ****************************************
  // core to bus clock ratios
  // ****************************************
  localparam logic [1:0]       RATIO_2   = 2'h0;
  localparam logic [1:0]       RATIO_2P5 = 2'h1;
  localparam logic [1:0]       RATIO_3   = 2'h2;
  localparam logic [1:0]       RATIO_4   = 2'h3;
  localparam logic [CNT_W-1:0] PER_2     = 3'h2;
  localparam logic [CNT_W-1:0] PER_3     = 3'h3;
  localparam logic [CNT_W-1:0] PER_4     = 3'h4;
  localparam logic [CNT_W-1:0] CNT_ONE   = 3'h1;

  // ****************************************
  // sequencer states and state record
  // ****************************************
  typedef enum logic [2:0] {
    S_PLL   = 3'b000,  // clock generator held in reset
    S_COLD  = 3'b001,  // cold reset held, fixed bus values
    S_ALIGN = 3'b010,  // waiting for first reference edge
    S_BOOT  = 3'b011,  // first fetch pending
    S_RUN   = 3'b100   // normal operation
  } rcmi_seq_t;

  typedef struct packed {
    rcmi_seq_t        state;
    logic             pll_s1, pll_s2, rst_s1, rst_s2;
    logic             ref_s1, ref_s2, ref_d;
    logic             proto_s1, proto_s2, order_s1, order_s2;
    logic             tdis_s1, tdis_s2;
    logic [1:0]       ratio_s1, ratio_s2;
    logic             proto, big, timer_en, rev, user_big;
    logic [1:0]       ratio;
    logic [CNT_W-1:0] cnt;
    logic             half_sel, bus_clk, bus_tick;
    logic             pll_init, core_run, master;
    logic [CMD_W-1:0] cmd_out;
    logic [AD_W-1:0]  ad_out;
    logic             ad_oe, cmd_oe, valid_n, release_n;
    logic             fetch_req, uncached;
    logic [AD_W-1:0]  fetch_addr;
    logic [REG_DW-1:0] rdata;
  } rcmi_state_t;

  localparam rcmi_state_t RESET_STATE = '{
    state: S_PLL, pll_init: 1'b1, cmd_out: CMD_COLD, ad_out: AD_COLD,
    ad_oe: 1'b1, cmd_oe: 1'b1, master: 1'b1, valid_n: 1'b1,
    release_n: 1'b1, default: '0};

endpackage

// ==== logic/rcmi_top.sv ====
/*
 * reset sequencer, mode strap capture and bus clock generation.
 * assumes: clk is the core clock; every pin input is asynchronous
 * to it; user_mode comes from core logic on clk; board logic
 * sequences the two resets in the documented order.
 */
`timescale 1ns/1ps

module rcmi_top
  import rcmi_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        arst_n,
  input  wire logic                        clk_en,
  input  wire logic                        pll_reset_n,
  input  wire logic                        full_reset_n,
  input  wire logic                        ref_clock_in,
  input  wire logic                        bus_protocol_select,
  input  wire logic [1:0]                  core_ratio_select,
  input  wire logic                        byte_order_strap,
  input  wire logic                        timer_irq_disable_n,
  input  wire logic                        user_mode,
  input  wire logic [rcmi_pkg::REG_AW-1:0] reg_addr,
  input  wire logic [rcmi_pkg::REG_DW-1:0] reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [rcmi_pkg::REG_DW-1:0] reg_rdata,
  output logic                             pll_init_out,
  output logic                             core_clock_run,
  output logic                             bus_interface_clock,
  output logic                             bus_launch,
  output logic                             bus_master,
  output logic      [rcmi_pkg::AD_W-1:0]   sys_addr_data_bus_out,
  output logic                             sys_addr_data_bus_oe,
  output logic      [rcmi_pkg::CMD_W-1:0]  sys_command_bus_out,
  output logic                             sys_command_bus_oe,
  output logic                             proc_valid_out_n,
  output logic                             proc_release_n,
  output logic                             fetch_req,
  output logic      [rcmi_pkg::AD_W-1:0]   fetch_addr,
  output logic                             fetch_uncached,
  output logic                             protocol_mode,
  output logic                             big_order_flag,
  output logic                             active_big_order,
  output logic                             timer_irq_enable
);
  import rcmi_pkg::*;

  // ****************************************
  // state record
  // ****************************************
  rcmi_state_t      s_reg;    // registered state
  rcmi_state_t      s_next;   // next state
  logic             ref_rise; // reference clock rising edge seen
  logic [CNT_W-1:0] per;      // current bus clock period in cycles
  logic             phase_on; // bus clock generator running

  // ****************************************
  // next state
  // ****************************************
  // one process computes everything; clk_en low freezes it all
  always_comb begin
    s_next   = s_reg;
    ref_rise = s_reg.ref_s2 & ~s_reg.ref_d;
    phase_on = 1'b0;
    // 2.5 alternates periods of two and three core cycles
    case (s_reg.ratio)
      RATIO_2:   per = PER_2;
      RATIO_2P5: per = s_reg.half_sel ? PER_3 : PER_2;
      RATIO_3:   per = PER_3;
      RATIO_4:   per = PER_4;
      default:   per = PER_2;
    endcase
    if (clk_en) begin
      // two flops per pin, a third on the reference for edge detection; the first stage only feeds the second
      s_next.pll_s1   = pll_reset_n;
      s_next.pll_s2   = s_reg.pll_s1;
      s_next.rst_s1   = full_reset_n;
      s_next.rst_s2   = s_reg.rst_s1;
      s_next.ref_s1   = ref_clock_in;
      s_next.ref_s2   = s_reg.ref_s1;
      s_next.ref_d    = s_reg.ref_s2;
      s_next.proto_s1 = bus_protocol_select;
      s_next.proto_s2 = s_reg.proto_s1;
      s_next.ratio_s1 = core_ratio_select;
      s_next.ratio_s2 = s_reg.ratio_s1;
      s_next.order_s1 = byte_order_strap;
      s_next.order_s2 = s_reg.order_s1;
      s_next.tdis_s1  = timer_irq_disable_n;
      s_next.tdis_s2  = s_reg.tdis_s1;

      // pulses and read data last one cycle only
      s_next.fetch_req = 1'b0;
      s_next.bus_tick  = 1'b0;
      s_next.rdata     = '0;

      // register port: reads answer next cycle, unmapped read zero
      if (reg_rd) begin
        case (reg_addr)
          OFS_CONFIG: begin
            s_next.rdata[CFG_BIG]            = s_reg.big;
            s_next.rdata[CFG_PROTO]          = s_reg.proto;
            s_next.rdata[CFG_RATIO_LO +: 2]  = s_reg.ratio;
            s_next.rdata[CFG_TIMER]          = s_reg.timer_en;
          end
          OFS_STATUS: s_next.rdata[STS_REV] = s_reg.rev;
          OFS_SEQ: begin
            s_next.rdata[SEQ_STATE_LO +: 3] = s_reg.state;
            s_next.rdata[SEQ_RUN]           = s_reg.core_run;
            s_next.rdata[SEQ_MASTER]        = s_reg.master;
          end
          default: s_next.rdata = '0;
        endcase
      end
      // config is read only; writes there are dropped
      if (reg_wr && reg_addr == OFS_STATUS) begin
        s_next.rev = reg_wdata[STS_REV];
      end

      // order in force: reversed only while in user mode
      s_next.user_big = s_reg.big ^ (s_reg.rev & user_mode);

      case (s_reg.state)
        // clock generator held; leaves only once pll reset drops
        S_PLL: begin
          if (s_reg.pll_s2) begin
            s_next.state = S_COLD;
          end
        end
        // cold reset held; board keeps it long enough to lock
        S_COLD: begin
          if (s_reg.rst_s2) begin
            // straps caught once, at the release
            s_next.big      = s_reg.order_s2;
            s_next.proto    = s_reg.proto_s2;
            s_next.ratio    = s_reg.ratio_s2;
            s_next.timer_en = ~s_reg.tdis_s2;
            s_next.core_run = 1'b1;
            s_next.state    = S_ALIGN;
          end
        end
        // hold bus clock low until the reference edge arrives
        S_ALIGN: begin
          if (ref_rise) begin
            phase_on     = 1'b1;
            s_next.state = S_BOOT;
          end
        end
        S_BOOT, S_RUN: begin
          phase_on = 1'b1;
        end
        default: begin
          s_next.state = S_PLL;
        end
      endcase

      // bus clock counted off the core clock, realigned on every
      // reference edge so it keeps the reference phase
      if (phase_on) begin
        if (ref_rise) begin
          s_next.cnt      = '0;
          // take the longer half of a 2.5 pair until the next edge,
          // so the counter can never tick ahead of the reference
          s_next.half_sel = 1'b1;
          s_next.bus_tick = 1'b1;
        end else if (s_reg.cnt == per - CNT_ONE) begin
          s_next.cnt      = '0;
          s_next.half_sel = ~s_reg.half_sel;
          s_next.bus_tick = 1'b1;
        end else begin
          s_next.cnt = s_reg.cnt + CNT_ONE;
        end
        s_next.bus_clk = s_next.cnt < (per >> 1);
      end

      // outputs change only with a bus clock rising edge
      if (s_next.bus_tick) begin
        s_next.master  = 1'b1;
        s_next.ad_oe   = 1'b1;
        s_next.cmd_oe  = 1'b1;
        if (s_reg.state == S_BOOT) begin
          // reset vector on the bus and to the fetch unit
          s_next.ad_out     = RESET_VECTOR;
          s_next.fetch_req  = 1'b1;
          s_next.fetch_addr = RESET_VECTOR;
          s_next.uncached   =
            (RESET_VECTOR[SEG_HI:SEG_LO] == UNCACHED_SEG);
          s_next.state      = S_RUN;
        end
      end

      // either reset wins from any state; pll reset goes deepest
      if (!s_reg.rst_s2) begin
        s_next.state = S_COLD;
      end
      if (!s_reg.pll_s2) begin
        s_next.state = S_PLL;
      end

      // while held, run state and the reverse bit clear and the bus shows fixed values;
      // agents mid-transfer must be reset by the board to avoid a
      // fight on the shared bus
      if (s_next.state == S_PLL || s_next.state == S_COLD) begin
        s_next.core_run  = 1'b0;
        s_next.rev       = 1'b0;
        s_next.cnt       = '0;
        s_next.half_sel  = 1'b0;
        s_next.bus_clk   = 1'b0;
        s_next.bus_tick  = 1'b0;
        s_next.fetch_req = 1'b0;
        s_next.master    = 1'b1;
        s_next.ad_oe     = 1'b1;
        s_next.cmd_oe    = 1'b1;
        s_next.ad_out    = AD_COLD;
        s_next.cmd_out   = CMD_COLD;
        s_next.valid_n   = 1'b1;
        s_next.release_n = 1'b1;
      end
      s_next.pll_init = (s_next.state == S_PLL);
    end
  end

  // ****************************************
  // state register
  // ****************************************
  // single register on the core clock; reset loads a constant
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= RESET_STATE;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************
  // outputs, all straight from the record
  // ****************************************
  assign reg_rdata             = s_reg.rdata;
  assign pll_init_out          = s_reg.pll_init;
  assign core_clock_run        = s_reg.core_run;
  assign bus_interface_clock   = s_reg.bus_clk;
  assign bus_launch            = s_reg.bus_tick;
  assign bus_master            = s_reg.master;
  assign sys_addr_data_bus_out = s_reg.ad_out;
  assign sys_addr_data_bus_oe  = s_reg.ad_oe;
  assign sys_command_bus_out   = s_reg.cmd_out;
  assign sys_command_bus_oe    = s_reg.cmd_oe;
  assign proc_valid_out_n      = s_reg.valid_n;
  assign proc_release_n        = s_reg.release_n;
  assign fetch_req             = s_reg.fetch_req;
  assign fetch_addr            = s_reg.fetch_addr;
  assign fetch_uncached        = s_reg.uncached;
  assign protocol_mode         = s_reg.proto;
  assign big_order_flag        = s_reg.big;
  assign active_big_order      = s_reg.user_big;
  assign timer_irq_enable      = s_reg.timer_en;

  // ****************************************
  // checks
  // ****************************************
  a_pll_reset_entry: assert property (
    @(posedge clk) disable iff (!arst_n)
    (clk_en && !s_reg.pll_s2) |=> (s_reg.state == S_PLL && s_reg.pll_init))
    else $error("pll reset did not hold clock generator");

  a_cold_clears: assert property (
    @(posedge clk) disable iff (!arst_n)
    (clk_en && s_reg.pll_s2 && !s_reg.rst_s2)
      |=> (s_reg.state == S_COLD && !s_reg.core_run && !s_reg.rev))
    else $error("cold reset left state behind");

  a_cold_bus_values: assert property (
    @(posedge clk) disable iff (!arst_n)
    (s_reg.state == S_COLD) |-> (s_reg.cmd_out == CMD_COLD
      && s_reg.valid_n && s_reg.release_n && s_reg.cmd_oe))
    else $error("wrong bus values while cold reset held");

  a_strap_capture: assert property (
    @(posedge clk) disable iff (!arst_n)
    (clk_en && s_reg.state == S_COLD && s_reg.rst_s2 && s_reg.pll_s2)
      |=> (s_reg.big == $past(s_reg.order_s2)
        && s_reg.timer_en == !$past(s_reg.tdis_s2)))
    else $error("straps not captured at release");

  a_flag_read_only: assert property (
    @(posedge clk) disable iff (!arst_n)
    (clk_en && reg_wr && reg_addr == OFS_CONFIG
      && s_reg.state == S_RUN && s_reg.rst_s2 && s_reg.pll_s2)
      |=> $stable(s_reg.big))
    else $error("config write changed the order flag");

  a_user_order: assert property (
    @(posedge clk) disable iff (!arst_n)
    clk_en |=> (s_reg.user_big
      == ($past(s_reg.big) ^ ($past(s_reg.rev) & $past(user_mode)))))
    else $error("user mode order wrong");

  a_first_edge: assert property (
    @(posedge clk) disable iff (!arst_n)
    (clk_en && s_reg.state == S_ALIGN && ref_rise
      && s_reg.rst_s2 && s_reg.pll_s2)
      |=> (s_reg.bus_clk && s_reg.bus_tick && s_reg.state == S_BOOT))
    else $error("first bus clock edge not aligned");

  a_boot_fetch: assert property (
    @(posedge clk) disable iff (!arst_n)
    s_reg.fetch_req |-> (s_reg.fetch_addr == RESET_VECTOR
      && s_reg.uncached && s_reg.bus_tick && s_reg.state == S_RUN))
    else $error("boot fetch wrong");

  a_run_master: assert property (
    @(posedge clk) disable iff (!arst_n)
    (s_reg.state == S_RUN) |-> (s_reg.master && s_reg.ad_oe
      && s_reg.cmd_oe && s_reg.core_run))
    else $error("not bus master while running");

  a_bus_launch: assert property (
    @(posedge clk) disable iff (!arst_n)
    (s_reg.state == S_RUN && !s_reg.bus_tick)
      |-> $stable(s_reg.ad_out))
    else $error("bus output moved off the bus clock edge");

  a_mode_capture: assert property (
    @(posedge clk) disable iff (!arst_n)
    (clk_en && s_reg.state == S_COLD && s_reg.rst_s2 && s_reg.pll_s2)
      |=> (s_reg.proto == $past(s_reg.proto_s2)
        && s_reg.ratio == $past(s_reg.ratio_s2)))
    else $error("protocol or ratio strap not captured");

  a_core_start: assert property (
    @(posedge clk) disable iff (!arst_n)
    $rose(s_reg.core_run)
      |-> (s_reg.state == S_ALIGN && $past(s_reg.rst_s2)))
    else $error("core clock started without cold release");

  a_sync_release: assert property (
    @(posedge clk) disable iff (!arst_n)
    (s_reg.state == S_COLD && !s_reg.rst_s2)
      |=> (s_reg.state != S_ALIGN && !s_reg.core_run))
    else $error("left cold reset before synced release");

  a_align_quiet: assert property (
    @(posedge clk) disable iff (!arst_n)
    (s_reg.state == S_ALIGN)
      |-> (!s_reg.bus_clk && !s_reg.bus_tick && !s_reg.fetch_req))
    else $error("bus clock ran before first reference edge");

  a_tick_high: assert property (
    @(posedge clk) disable iff (!arst_n)
    s_reg.bus_tick |-> (s_reg.bus_clk && s_reg.state != S_COLD
      && s_reg.state != S_PLL))
    else $error("bus clock low at its rising edge");

endmodule

// ==== testbench/rcmi_board_model.sv ====
/*
 * board reset logic and master clock source facing the block.
 * assumes: clk is the core clock; the master clock period in core
 * cycles follows the ratio straps; go pulses request a reset run.
 */
`timescale 1ns/1ps
module rcmi_board_model
  import rcmi_pkg::*;
#(
  parameter int PLL_SETTLE = 20,  // pll settling wait, core cycles
  parameter int COLD_REFS  = 16   // cold hold, master clock cycles
)(
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic       cold_only,
  input  wire logic [1:0] ratio_sel,
  output logic            pll_reset_n,
  output logic            full_reset_n,
  output logic            ref_clock_in
);
  // ****************************************
  // master clock, free running
  // ****************************************
  logic [2:0] ref_cnt = 3'h0;  // position in master period
  logic       alt     = 1'b0;  // picks 2 or 3 for the 2.5 ratio
  logic [2:0] per;             // current period in core cycles
  initial ref_clock_in = 1'b0;
  // period per ratio code; 2.5 alternates so two periods make five
  always_comb begin
    case (ratio_sel)
      RATIO_2:   per = 3'h2;
      RATIO_2P5: per = alt ? 3'h3 : 3'h2;
      RATIO_3:   per = 3'h3;
      default:   per = 3'h4;
    endcase
  end
  // the agent and the block share this one clock
  always @(posedge clk) begin
    if (ref_cnt >= per - 3'h1) begin
      ref_cnt <= 3'h0;
      alt <= ~alt;
      ref_clock_in <= 1'b1;
    end else begin
      ref_cnt <= ref_cnt + 3'h1;
      ref_clock_in <= (ref_cnt + 3'h1) < (per >> 1);
    end
  end
  // ****************************************
  // reset sequencing
  // ****************************************
  // edges are placed off the clock edge on purpose, the block must cope
  initial begin
    pll_reset_n = 1'b0;
    full_reset_n = 1'b0;
    forever begin
      @(posedge clk iff go);
      #2.1;
      full_reset_n = 1'b0;
      pll_reset_n = cold_only;
      if (!cold_only) begin
        repeat (PLL_SETTLE) @(posedge clk);
      end
      #3.3 pll_reset_n = 1'b1;
      repeat (COLD_REFS) @(posedge ref_clock_in);
      #1.7 full_reset_n = 1'b1;
    end
  end
endmodule

// ==== testbench/testbench.sv ====
/*
 * self-checking bench of the reset, clock and mode block.
 * assumes: the board model makes both resets and the master clock;
 * registers are reached through the plain register port.
 */
`timescale 1ns/1ps
module testbench;
  import rcmi_pkg::*;
  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic              clk = 1'b0, arst_n, clk_en, go, cold_only, user_mode;
  logic              bus_protocol_select, byte_order_strap;
  logic              timer_irq_disable_n, reg_wr, reg_rd;
  logic [1:0]        core_ratio_select;
  logic [REG_AW-1:0] reg_addr;
  logic [REG_DW-1:0] reg_wdata, reg_rdata;
  logic              pll_reset_n, full_reset_n, ref_clock_in;
  logic              pll_init_out, core_clock_run, bus_interface_clock;
  logic              bus_launch, bus_master, sys_addr_data_bus_oe;
  logic              sys_command_bus_oe, proc_valid_out_n, proc_release_n;
  logic              fetch_req, fetch_uncached, protocol_mode;
  logic              big_order_flag, active_big_order, timer_irq_enable;
  logic [AD_W-1:0]   sys_addr_data_bus_out, fetch_addr;
  logic [CMD_W-1:0]  sys_command_bus_out;
  int                failures = 0, checks = 0;
  int                twice [4] = '{4, 5, 6, 8};  // two bus periods
  always #2.5 clk = ~clk;
  rcmi_board_model i_board (.clk(clk), .go(go), .cold_only(cold_only),
    .ratio_sel(core_ratio_select), .pll_reset_n(pll_reset_n),
    .full_reset_n(full_reset_n), .ref_clock_in(ref_clock_in));
  rcmi_top i_dut (.clk(clk), .arst_n(arst_n), .clk_en(clk_en),
    .pll_reset_n(pll_reset_n), .full_reset_n(full_reset_n),
    .ref_clock_in(ref_clock_in), .bus_protocol_select(bus_protocol_select),
    .core_ratio_select(core_ratio_select),
    .byte_order_strap(byte_order_strap),
    .timer_irq_disable_n(timer_irq_disable_n), .user_mode(user_mode),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pll_init_out(pll_init_out),
    .core_clock_run(core_clock_run),
    .bus_interface_clock(bus_interface_clock), .bus_launch(bus_launch),
    .bus_master(bus_master), .sys_addr_data_bus_out(sys_addr_data_bus_out),
    .sys_addr_data_bus_oe(sys_addr_data_bus_oe),
    .sys_command_bus_out(sys_command_bus_out),
    .sys_command_bus_oe(sys_command_bus_oe),
    .proc_valid_out_n(proc_valid_out_n), .proc_release_n(proc_release_n),
    .fetch_req(fetch_req), .fetch_addr(fetch_addr),
    .fetch_uncached(fetch_uncached), .protocol_mode(protocol_mode),
    .big_order_flag(big_order_flag), .active_big_order(active_big_order),
    .timer_irq_enable(timer_irq_enable));
  // ****************************************
  // shared tasks
  // ****************************************
  // one comparison, counted; x never matches
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [31:0] w);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= w;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // bounded wait: 0 run, 1 fetch, 2 bus launch; n gives edges waited
  task automatic wait_hi(input int sel, input int lim, output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (!(sel == 0 ? core_clock_run === 1'b1 : sel == 1 ?
      fetch_req === 1'b1 : bus_launch === 1'b1) && n < lim);
    if (n >= lim) check(32'h0, 32'h1);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  // full or cold-only reset run with given straps, then boot checks
  task automatic boot(input logic [1:0] r, input logic p, o, t, c);
    logic [31:0] d, cfg;
    int          c1, c2, skip;
    @(posedge clk);
    core_ratio_select <= r;
    bus_protocol_select <= p;
    byte_order_strap <= o;
    timer_irq_disable_n <= t;
    cold_only <= c;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (6) @(posedge clk);
    #1 check({31'h0, pll_init_out}, {31'h0, ~c});
    check({31'h0, core_clock_run}, 32'h0);
    check({23'h0, sys_command_bus_out}, {23'h0, CMD_COLD});
    check({27'h0, sys_command_bus_oe, sys_addr_data_bus_oe,
      proc_valid_out_n, proc_release_n, bus_master}, 32'h1F);
    wait_hi(0, 400, skip);
    check({29'h0, protocol_mode, big_order_flag, timer_irq_enable},
      {29'h0, p, o, ~t});
    cfg = '0;
    cfg[CFG_BIG] = o;
    cfg[CFG_PROTO] = p;
    cfg[CFG_RATIO_LO +: 2] = r;
    cfg[CFG_TIMER] = ~t;
    reg_read(OFS_CONFIG, d);
    check(d, cfg);
    wait_hi(1, 40, skip);
    check(fetch_addr, RESET_VECTOR);
    check({31'h0, fetch_uncached}, 32'h1);
    check(sys_addr_data_bus_out, RESET_VECTOR);
    wait_hi(2, 20, skip);
    wait_hi(2, 20, c1);
    wait_hi(2, 20, c2);
    check(32'(c1 + c2), 32'(twice[r]));
    check({31'h0, bus_interface_clock}, 32'h1);
    @(posedge clk);
    #1 check({31'h0, bus_interface_clock}, {31'h0, r == RATIO_4});
  endtask
  // reverse bit, read-only config, unmapped and sequencer reads
  task automatic user_order;
    logic [31:0] d;
    reg_write(OFS_STATUS, 32'h1);
    reg_write(OFS_CONFIG, 32'hFFFF_FFFF);
    reg_read(OFS_STATUS, d);
    check(d, 32'h1);
    reg_read(OFS_CONFIG, d);
    check(d, 32'h1F);
    reg_read(8'h0C, d);
    check(d, 32'h0);
    reg_read(OFS_SEQ, d);
    check({30'h0, d[SEQ_MASTER], d[SEQ_RUN]}, 32'h3);
    @(posedge clk);
    clk_en <= 1'b0;
    user_mode <= 1'b1;
    repeat (3) @(posedge clk);
    #1 check({31'h0, active_big_order}, 32'h1);
    @(posedge clk);
    clk_en <= 1'b1;
    repeat (3) @(posedge clk);
    #1 check({31'h0, active_big_order}, 32'h0);
    @(posedge clk);
    user_mode <= 1'b0;
    repeat (3) @(posedge clk);
    #1 check({31'h0, active_big_order}, 32'h1);
  endtask
  // late strap change ignored, then a cold reset clears state
  task automatic cold_again;
    logic [31:0] d;
    @(posedge clk);
    byte_order_strap <= 1'b0;
    bus_protocol_select <= 1'b0;
    timer_irq_disable_n <= 1'b1;
    repeat (8) @(posedge clk);
    #1 check({29'h0, protocol_mode, big_order_flag, timer_irq_enable},
      32'h7);
    boot(2'h3, 1'b0, 1'b0, 1'b1, 1'b1);
    reg_read(OFS_STATUS, d);
    check(d, 32'h0);
  endtask
  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    logic [1:0] rr;
    {arst_n, go, cold_only, user_mode, reg_wr, reg_rd} = '0;
    {bus_protocol_select, byte_order_strap, timer_irq_disable_n} = '0;
    clk_en = 1'b1;
    core_ratio_select = 2'h0;
    reg_addr = '0;
    reg_wdata = '0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rr = 2'(i);
      boot(rr, rr[0], rr[1], ~rr[0], 1'b0);
    end
    user_order;
    cold_again;
    complete_run;
  end
  // the whole run needs under 1500 cycles; this is ample margin
  initial begin
    #40000;
    failures++;
    complete_run;
  end
endmodule
